/* File: rtl/lsl_regs.vh */
`ifndef LSL_REGS_VH
`define LSL_REGS_VH
`define LSL_ADDR_STEP     8'h0a
`define LSL_ADDR_SINK_A   8'h0b
`define LSL_ADDR_SINK_B   8'h0c
`define LSL_ADDR_SINK_C   8'h0d
`define LSL_ADDR_LOCK     8'h0e
`define LSL_ADDR_INPUT_LEVEL_STATUS     8'h0f
`define LSL_LOCK_CODE     8'ha5
`define LSL_ZERO8         8'h00
`define LSL_SEL_OFF       3'h0
`define LSL_SEL_ON        3'h1
`define LSL_SEL_CABLE     3'h2
`define LSL_SEL_CHARGER   3'h3
`define LSL_SEL_PA_RAW    3'h4
`define LSL_SEL_PA_PWM    3'h5
`define LSL_SEL_PB_RAW    3'h6
`define LSL_SEL_PB_PWM    3'h7
`define LSL_LEVEL_MAX     5'h18
`define LSL_STEPS_MAX     5'h19
`define LSL_STEP_0P6      2'h0
`define LSL_STEP_1P0      2'h1
`define LSL_STEP_1P2      2'h2
`define LSL_PWM_FILT_NS   10000
`define LSL_CLK_NS        10
`define LSL_PWM_FILT_CYC  (`LSL_PWM_FILT_NS / `LSL_CLK_NS)
`define LSL_PWM_CNT_W     10
`define LSL_PWM_FILT_MAX  10'h3e8
`define LSL_BIT_KEY       4
`define LSL_BIT_LOCKPIN   3
`define LSL_BIT_PIN_B     1
`define LSL_BIT_PIN_A     0
`endif

/* File: rtl/lsl_sink_regs.v */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "lsl_regs.vh"
module lsl_sink_regs (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  input  wire       cablePresentFlag,
  input  wire       chargerStatus,
  input  wire       multiCtlPinA,
  input  wire       multiCtlPinB,
  input  wire       keyOutState,
  input  wire       lockPin,
  output reg  [2:0] sinkOn,
  output reg  [1:0] sinkStepSelect,
  output reg  [14:0] sinkSteps,
  output reg        lockEnterPulse
);

  reg  [1:0] stepSel_r;
  reg  [7:0] sinkCfg_r [0:2];
  reg  [1:0] pinA_r;
  reg  [1:0] pinB_r;
  reg  [1:0] keyOut_r;
  reg  [1:0] lockPin_r;
  reg  [1:0] cable_r;
  reg  [1:0] charger_r;
  reg  [`LSL_PWM_CNT_W-1:0] filtCntA_r;
  reg  [`LSL_PWM_CNT_W-1:0] filtCntB_r;
  reg        filtA_r;
  reg        filtB_r;
  wire [7:0] pinState;
  wire [`LSL_PWM_CNT_W-1:0] filtMax;

  // sized copy of the filter window so the compare width matches the counter
  assign filtMax = `LSL_PWM_FILT_MAX;

  // two-stage synchronisers; only stage 2 is read by logic
  always @(posedge clk_sys) begin
    if (!resetn) begin
      pinA_r    <= 2'h0;
      pinB_r    <= 2'h0;
      keyOut_r  <= 2'h0;
      lockPin_r <= 2'h0;
      cable_r   <= 2'h0;
      charger_r <= 2'h0;
    end else begin
      pinA_r    <= {pinA_r[0], multiCtlPinA};
      pinB_r    <= {pinB_r[0], multiCtlPinB};
      keyOut_r  <= {keyOut_r[0], keyOutState};
      lockPin_r <= {lockPin_r[0], lockPin};
      cable_r   <= {cable_r[0], cablePresentFlag};
      charger_r <= {charger_r[0], chargerStatus};
    end
  end

  // pwm filter: output follows the pin only after it held steady for the window,
  // so a pwm-driven pin appears as its settled level rather than toggling
  always @(posedge clk_sys) begin
    if (!resetn) begin
      filtCntA_r <= {`LSL_PWM_CNT_W{1'b0}};
      filtCntB_r <= {`LSL_PWM_CNT_W{1'b0}};
      filtA_r    <= 1'b0;
      filtB_r    <= 1'b0;
    end else begin
      if (pinA_r[1] == filtA_r) begin
        filtCntA_r <= {`LSL_PWM_CNT_W{1'b0}};
      end else if (filtCntA_r == filtMax) begin
        filtA_r    <= pinA_r[1];
        filtCntA_r <= {`LSL_PWM_CNT_W{1'b0}};
      end else begin
        filtCntA_r <= filtCntA_r + 1'b1;
      end
      if (pinB_r[1] == filtB_r) begin
        filtCntB_r <= {`LSL_PWM_CNT_W{1'b0}};
      end else if (filtCntB_r == filtMax) begin
        filtB_r    <= pinB_r[1];
        filtCntB_r <= {`LSL_PWM_CNT_W{1'b0}};
      end else begin
        filtCntB_r <= filtCntB_r + 1'b1;
      end
    end
  end

  // register writes; pin-state writes fall through and are dropped
  always @(posedge clk_sys) begin
    if (!resetn) begin
      stepSel_r    <= 2'h0;
      sinkCfg_r[0] <= `LSL_ZERO8;
      sinkCfg_r[1] <= `LSL_ZERO8;
      sinkCfg_r[2] <= `LSL_ZERO8;
    end else if (regWrite) begin
      case (regAddr)
        `LSL_ADDR_STEP:   stepSel_r    <= regWdata[1:0];
        `LSL_ADDR_SINK_A: sinkCfg_r[0] <= regWdata;
        `LSL_ADDR_SINK_B: sinkCfg_r[1] <= regWdata;
        `LSL_ADDR_SINK_C: sinkCfg_r[2] <= regWdata;
        default: ;
      endcase
    end
  end

  // lock command: one-cycle pulse only on the exact code
  always @(posedge clk_sys) begin
    if (!resetn) begin
      lockEnterPulse <= 1'b0;
    end else begin
      lockEnterPulse <= regWrite && (regAddr == `LSL_ADDR_LOCK) &&
                        (regWdata == `LSL_LOCK_CODE);
    end
  end

  assign pinState = {3'h0, keyOut_r[1], lockPin_r[1], 1'b0,
                     pinB_r[1], pinA_r[1]};

  always @(posedge clk_sys) begin
    if (!resetn) begin
      regRdata <= `LSL_ZERO8;
    end else if (regRead) begin
      case (regAddr)
        `LSL_ADDR_STEP:   regRdata <= {6'h0, stepSel_r};
        `LSL_ADDR_SINK_A: regRdata <= sinkCfg_r[0];
        `LSL_ADDR_SINK_B: regRdata <= sinkCfg_r[1];
        `LSL_ADDR_SINK_C: regRdata <= sinkCfg_r[2];
        `LSL_ADDR_LOCK:   regRdata <= `LSL_ZERO8;
        `LSL_ADDR_INPUT_LEVEL_STATUS:   regRdata <= pinState;
        default:          regRdata <= `LSL_ZERO8;
      endcase
    end else begin
      regRdata <= `LSL_ZERO8;
    end
  end

  // step code 11 folds onto 10: both mean the largest step
  always @(posedge clk_sys) begin
    if (!resetn) begin
      sinkStepSelect <= `LSL_STEP_0P6;
    end else if (stepSel_r[1]) begin
      sinkStepSelect <= `LSL_STEP_1P2;
    end else begin
      sinkStepSelect <= stepSel_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSink
      wire [2:0] sel;
      wire [4:0] lvl;
      reg        gate;
      assign sel = sinkCfg_r[gi][7:5];
      assign lvl = sinkCfg_r[gi][4:0];
      always @* begin
        case (sel)
          `LSL_SEL_OFF:     gate = 1'b0;
          `LSL_SEL_ON:      gate = 1'b1;
          `LSL_SEL_CABLE:   gate = cable_r[1];
          `LSL_SEL_CHARGER: gate = charger_r[1];
          `LSL_SEL_PA_RAW:  gate = pinA_r[1];
          `LSL_SEL_PA_PWM:  gate = filtA_r;
          `LSL_SEL_PB_RAW:  gate = pinB_r[1];
          `LSL_SEL_PB_PWM:  gate = filtB_r;
          default:          gate = 1'b0;
        endcase
      end
      always @(posedge clk_sys) begin
        if (!resetn) begin
          sinkOn[gi]           <= 1'b0;
          sinkSteps[gi*5 +: 5] <= 5'h0;
        end else begin
          sinkOn[gi] <= gate;
          if (lvl >= `LSL_LEVEL_MAX) begin
            sinkSteps[gi*5 +: 5] <= `LSL_STEPS_MAX;
          end else begin
            sinkSteps[gi*5 +: 5] <= lvl + 5'h1;
          end
        end
      end
    end
  endgenerate

endmodule

/* File: verification/lsl_regs_chk.sv */
`timescale 1ns/1ps
module lsl_regs_chk (
  input logic        clk_sys,
  input logic        resetn,
  input logic [7:0]  regAddr,
  input logic [7:0]  regWdata,
  input logic        regWrite,
  input logic        regRead,
  input logic [7:0]  regRdata,
  input logic [2:0]  sinkOn,
  input logic [1:0]  sinkStepSelect,
  input logic [14:0] sinkSteps,
  input logic        lockEnterPulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_lock_wr;
    regWrite && regAddr == 8'h0e && regWdata == 8'ha5;
  endsequence
  sequence s_sel_wr(c);
    regWrite && regAddr == 8'h0b && regWdata[7:5] == c;
  endsequence
  a_lock_pulse:
    assert property (s_lock_wr |=> lockEnterPulse) else $error("lock pulse missing");
  a_lock_cause:
    assert property (lockEnterPulse |-> $past(regWrite && regAddr == 8'h0e && regWdata == 8'ha5)) else $error("stray lock");
  a_lock_reads:
    assert property (regRead && regAddr == 8'h0e |=> regRdata == 8'h00) else $error("lock read not zero");
  a_pin_unused:
    assert property (regRead && regAddr == 8'h0f |=> (regRdata & 8'he4) == 8'h00) else $error("unused pin bits set");
  a_steps_sat:
    assert property (sinkSteps[4:0] <= 5'h19 && sinkSteps[9:5] <= 5'h19 && sinkSteps[14:10] <= 5'h19)
      else $error("steps above 25");
  a_step_code:
    assert property (sinkStepSelect != 2'h3) else $error("bad step code");
  a_sink_on:
    assert property (s_sel_wr(3'h1) |-> ##[1:3] sinkOn[0]) else $error("sink not on");
  a_sink_off:
    assert property (s_sel_wr(3'h0) |-> ##[1:3] !sinkOn[0]) else $error("sink not off");
endmodule
bind lsl_sink_regs lsl_regs_chk u_chk (.*);

/* File: verification/tb_led_sink_lock_pin_regs.sv */
`timescale 1ns/1ps
module tb_led_sink_lock_pin_regs;
  logic clk_sys = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, lockEnterPulse;
  logic cablePresentFlag = 1'b0, chargerStatus = 1'b0, multiCtlPinA = 1'b0, multiCtlPinB = 1'b0;
  logic keyOutState = 1'b0, lockPin = 1'b0;
  logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, q;
  logic [2:0]  sinkOn;
  logic [1:0]  sinkStepSelect;
  logic [14:0] sinkSteps;
  logic [7:0]  rCfg[4] = '{8'h22, 8'h18, 8'h3f, 8'h00};
  logic [1:0]  rStep[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0]  xSel[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic [4:0]  xSteps[4] = '{5'h03, 5'h19, 5'h19, 5'h01};
  logic [3:0]  xOn = 4'h5;
  logic [7:0]  pat[2] = '{8'h36, 8'hca};
  int miscompares = 0, n_compared = 0, cyc = 0;
  lsl_sink_regs DUT (.*);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [14:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 r = regRdata;
  endtask
  // whole run needs about 2350 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    repeat (15) @(posedge clk_sys);
    #1 cmp(sinkOn, 15'h0000);
    @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0a, {6'h00, rStep[i]});
      wr(8'h0b, rCfg[i]);
      repeat (3) @(posedge clk_sys);
      #1 cmp(sinkStepSelect, xSel[i]);
      cmp(sinkSteps[4:0], xSteps[i]);
      cmp(sinkOn[0], xOn[i]);
    end
    $display("table done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys);
      cablePresentFlag <= !p;
      multiCtlPinA <= !p;
      {chargerStatus, multiCtlPinB, keyOutState, lockPin} <= {4{p[0]}};
      // long settle so the filtered selectors see the new levels too
      repeat (1100) @(posedge clk_sys);
      for (int k = 0; k < 8; k++) begin
        wr(8'h0c, {k[2:0], 5'h00});
        repeat (3) @(posedge clk_sys);
        #1 cmp(sinkOn[1], pat[p][k]);
      end
      rd(8'h0f, q);
      cmp(q, {3'h0, p[0], p[0], 1'b0, p[0], !p[0]});
    end
    $display("sources done");
    wr(8'h0d, 8'h21);
    repeat (3) @(posedge clk_sys);
    #1 cmp(sinkSteps[14:10], 5'h02);
    cmp(sinkOn[2], 1'b1);
    cmp(sinkSteps[9:5], 5'h01);
    $display("sink c done");
    wr(8'h0f, 8'hff);
    rd(8'h0f, q);
    cmp(q, 8'h1a);
    wr(8'h0a, 8'hff);
    rd(8'h0a, q);
    cmp(q, 8'h03);
    rd(8'h20, q);
    cmp(q, 8'h00);
    wr(8'h0e, 8'h5a);
    #1 cmp(lockEnterPulse, 1'b0);
    wr(8'h0e, 8'ha5);
    #1 cmp(lockEnterPulse, 1'b1);
    rd(8'h0e, q);
    cmp(q, 8'h00);
    $display("lock done");
    stop_test;
  end
endmodule
